// File: verilog/wsp_top.sv
// WLAN enable power sequencer and SDIO command port of the combo module.
`timescale 1ns/100ps
module wsp_top
  import wsp_pkg::*;
#(
  parameter int unsigned RAMP_COUNT = RAMP_CYCLES
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic wlan_enable_pin_i,
  input wire logic high_speed_timing_i,
  input wire logic launch_rising_cfg_i,
  input wire logic sdio_clk_i,
  input wire logic sdio_cmd_i,
  input wire logic [DATA_WIDTH-1:0] sdio_dat_i,
  output logic sdio_cmd_o,
  output logic sdio_cmd_oe_o,
  output logic [DATA_WIDTH-1:0] sdio_dat_o,
  output logic sdio_dat_oe_o,
  output logic regulators_on_o,
  output logic clocks_on_o,
  output logic power_good_o,
  output logic asleep_o,
  output logic irq_req_i_dummy_o,
  input wire logic irq_req_i,
  output logic cmd_valid_o,
  output logic [5:0] cmd_index_o
);
  // The ramp counter is 16 bits wide, so longer ramps cannot be served.
  if (RAMP_COUNT < 1 || RAMP_COUNT > 65535) begin : g_bad_ramp
    $error("wsp_top RAMP_COUNT out of range");
  end

  // A synchronised level moves only once the last two of its three stages agree.
  function automatic logic agree_level(input logic [2:0] sync, input logic held);
    agree_level = (sync[2] == sync[1]) ? sync[2] : held;
  endfunction : agree_level

  // Enable pin: three flops, a change counts once the last two agree.
  logic [2:0] en_sync;
  logic en_level;
  logic next_en_level;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_sync <= 3'h0;
      en_level <= 1'b0;
    end else begin
      en_sync <= {en_sync[1:0], wlan_enable_pin_i};
      en_level <= next_en_level;
    end
  end
  always_comb begin
    next_en_level = agree_level(en_sync, en_level);
  end

  // Power state machine.
  wsp_pwr_t state;
  wsp_pwr_t next_state;
  logic [15:0] ramp_cnt;
  logic [15:0] next_ramp_cnt;
  logic sleep_req;
  logic wake_req;
  logic port_en_q;
  logic next_port_en;
  always_comb begin
    next_state = state;
    next_ramp_cnt = ramp_cnt;
    case (state)
      WSP_SHUTDOWN: begin
        next_ramp_cnt = 16'h0000;
        // Enable high starts the ramp.
        if (en_level) begin
          next_state = WSP_RAMP;
        end
      end
      WSP_RAMP: begin
        if (!en_level) begin
          next_state = WSP_SHUTDOWN;
        end else if (ramp_cnt == 16'(RAMP_COUNT - 1)) begin
          next_state = WSP_ACTIVE;
        end else begin
          next_ramp_cnt = ramp_cnt + 16'h0001;
        end
      end
      WSP_ACTIVE: begin
        if (!en_level) begin
          next_state = WSP_SHUTDOWN;
        end else if (sleep_req) begin
          next_state = WSP_SLEEP;
        end
      end
      WSP_SLEEP: begin
        if (!en_level) begin
          next_state = WSP_SHUTDOWN;
        end else if (wake_req) begin
          next_state = WSP_ACTIVE;
        end
      end
      default: begin
        next_state = WSP_SHUTDOWN;
      end
    endcase
    // Taken from the next state so the link side is cut at the same edge as the state.
    next_port_en = (next_state == WSP_ACTIVE) || (next_state == WSP_SLEEP);
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= WSP_SHUTDOWN;
      ramp_cnt <= 16'h0000;
      port_en_q <= 1'b0;
    end else begin
      state <= next_state;
      ramp_cnt <= next_ramp_cnt;
      port_en_q <= next_port_en;
    end
  end

  // In shutdown every regulator, clock and the SDIO port stay off.
  always_comb begin
    regulators_on_o = (state != WSP_SHUTDOWN);
    clocks_on_o = (state != WSP_SHUTDOWN);
    power_good_o = (state == WSP_ACTIVE) || (state == WSP_SLEEP);
    asleep_o = (state == WSP_SLEEP);
    irq_req_i_dummy_o = 1'b0;
  end

  // The link side is held in reset outside the powered states: the host may stop its
  // clock at any time, so only an asynchronous reset keeps the pins quiet then.
  logic link_rst_n;
  assign link_rst_n = arst_n_i & port_en_q;

  // Port enable, launch edge and interrupt request cross into the link domain as levels.
  logic [2:0] pe_sync;
  logic [2:0] hs_sync;
  logic [2:0] irq_sync;
  logic link_en;
  logic launch_rise;
  logic irq_level;
  logic next_link_en;
  logic next_launch_rise;
  logic next_irq_level;
  always_comb begin
    next_link_en = agree_level(pe_sync, link_en);
    next_launch_rise = agree_level(hs_sync, launch_rise);
    next_irq_level = agree_level(irq_sync, irq_level);
  end
  always_ff @(posedge sdio_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pe_sync <= 3'h0;
      hs_sync <= 3'h0;
      irq_sync <= 3'h0;
      link_en <= 1'b0;
      launch_rise <= 1'b0;
      irq_level <= 1'b0;
    end else begin
      pe_sync <= {pe_sync[1:0], port_en_q};
      hs_sync <= {hs_sync[1:0], high_speed_timing_i | launch_rising_cfg_i};
      irq_sync <= {irq_sync[1:0], irq_req_i};
      link_en <= next_link_en;
      launch_rise <= next_launch_rise;
      irq_level <= next_irq_level;
    end
  end

  // Link side: receive 48-bit command frames at up to 50 MHz, drive an in-band interrupt.
  // The end bit is left in the capture flop, so a frame completes on the last clock that
  // the host gives; the host may stop its clock right after it.
  logic cmd_cap;
  logic [CMD_BITS-1:0] shift;
  logic [CMD_BITS-1:0] next_shift;
  logic [5:0] bit_cnt;
  logic [5:0] next_bit_cnt;
  logic in_frame;
  logic next_in_frame;
  logic frame_tgl;
  logic next_frame_tgl;
  logic [5:0] frame_idx;
  logic [5:0] next_frame_idx;
  always_comb begin
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_in_frame = in_frame;
    next_frame_tgl = frame_tgl;
    next_frame_idx = frame_idx;
    if (!link_en) begin
      next_in_frame = 1'b0;
      next_bit_cnt = 6'h00;
    end else if (!in_frame) begin
      if (!cmd_cap) begin
        next_in_frame = 1'b1;
        next_bit_cnt = 6'h01;
        next_shift = {{(CMD_BITS-1){1'b0}}, 1'b0};
      end
    end else begin
      next_shift = {shift[CMD_BITS-2:0], cmd_cap};
      next_bit_cnt = bit_cnt + 6'h01;
      // Bits arrive from the rising-edge capture flop.
      if (bit_cnt == 6'(CMD_BITS - 2)) begin
        next_in_frame = 1'b0;
        next_frame_idx = shift[CMD_BITS-5:CMD_BITS-10];
        next_frame_tgl = ~frame_tgl;
      end
    end
  end
  always_ff @(posedge sdio_clk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift <= '0;
      bit_cnt <= 6'h00;
      in_frame <= 1'b0;
      frame_tgl <= 1'b0;
      frame_idx <= 6'h00;
    end else begin
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      in_frame <= next_in_frame;
      frame_tgl <= next_frame_tgl;
      frame_idx <= next_frame_idx;
    end
  end

  // Interrupt is signalled in band by driving all four DAT lines low between frames.
  wsp_sdio_edge #(
    .WIDTH(DATA_WIDTH)
  ) u_edge (
    .sdio_clk_i(sdio_clk_i),
    .link_rst_n_i(link_rst_n),
    .launch_rise_i(launch_rise),
    .port_en_i(link_en),
    .cmd_i(sdio_cmd_i),
    .dat_i(sdio_dat_i),
    .cmd_out_i(1'b1),
    .cmd_oe_i(1'b0),
    .dat_out_i(4'h0),
    .dat_oe_i(irq_level & ~in_frame),
    .cmd_cap_o(cmd_cap),
    .dat_cap_o(),
    .cmd_o(sdio_cmd_o),
    .cmd_oe_o(sdio_cmd_oe_o),
    .dat_o(sdio_dat_o),
    .dat_oe_o(sdio_dat_oe_o)
  );

  // Frame event returns to the system clock by toggle; index is stable by then.
  logic [2:0] tgl_sync;
  logic tgl_seen;
  logic [5:0] idx_hold;
  logic [5:0] next_idx_hold;
  logic next_valid;
  always_comb begin
    next_valid = (agree_level(tgl_sync, tgl_seen) != tgl_seen) && next_port_en;
    next_idx_hold = next_valid ? frame_idx : idx_hold;
    // Sleep and wake commands move the power state.
    sleep_req = cmd_valid_o && (cmd_index_o == CMD_SLEEP);
    wake_req = cmd_valid_o && (cmd_index_o == CMD_WAKE);
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tgl_sync <= 3'h0;
      tgl_seen <= 1'b0;
      idx_hold <= 6'h00;
      cmd_valid_o <= 1'b0;
    end else begin
      tgl_sync <= {tgl_sync[1:0], frame_tgl};
      tgl_seen <= agree_level(tgl_sync, tgl_seen);
      idx_hold <= next_idx_hold;
      cmd_valid_o <= next_valid;
    end
  end
  assign cmd_index_o = idx_hold;
endmodule : wsp_top

// File: verilog/wsp_pkg.sv
// Shared constants and types for the WLAN enable and SDIO port block.
package wsp_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned RAMP_TIME_NS = 2000;
  localparam int unsigned RAMP_CYCLES = (RAMP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SDIO_MAX_MHZ = 50;
  localparam int unsigned DATA_WIDTH = 4;
  localparam int unsigned CMD_BITS = 48;
  localparam logic [5:0] CMD_SLEEP = 6'h0_5;
  localparam logic [5:0] CMD_WAKE = 6'h0_6;
  typedef enum logic [1:0] {
    WSP_SHUTDOWN,
    WSP_RAMP,
    WSP_ACTIVE,
    WSP_SLEEP
  } wsp_pwr_t;
endpackage : wsp_pkg

// File: verilog/wsp_sdio_edge.sv
// SDIO link-side port: rising-edge capture and selectable output launch edge.
`timescale 1ns/100ps
module wsp_sdio_edge
  import wsp_pkg::*;
#(
  parameter int unsigned WIDTH = DATA_WIDTH
) (
  input wire logic sdio_clk_i,
  input wire logic link_rst_n_i,
  input wire logic launch_rise_i,
  input wire logic port_en_i,
  input wire logic cmd_i,
  input wire logic [WIDTH-1:0] dat_i,
  input wire logic cmd_out_i,
  input wire logic cmd_oe_i,
  input wire logic [WIDTH-1:0] dat_out_i,
  input wire logic dat_oe_i,
  output logic cmd_cap_o,
  output logic [WIDTH-1:0] dat_cap_o,
  output logic cmd_o,
  output logic cmd_oe_o,
  output logic [WIDTH-1:0] dat_o,
  output logic dat_oe_o
);
  if (WIDTH != 4) begin : g_bad_width
    $error("wsp_sdio_edge serves the 4-bit bus only");
  end
  logic cmd_cap;
  logic [WIDTH-1:0] dat_cap;
  logic [WIDTH+2:0] rise_q;
  logic [WIDTH+2:0] fall_q;
  logic [WIDTH+2:0] next_rise_q;
  logic [WIDTH+2:0] next_fall_q;
  always_comb begin
    next_rise_q = port_en_i ? {cmd_out_i, cmd_oe_i, dat_oe_i, dat_out_i} : '0;
    next_fall_q = rise_q;
  end
  // Inputs are captured on the rising edge in both timing modes.
  always_ff @(posedge sdio_clk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      cmd_cap <= 1'b1;
      dat_cap <= '1;
      rise_q <= '0;
    end else begin
      cmd_cap <= cmd_i;
      dat_cap <= dat_i;
      rise_q <= next_rise_q;
    end
  end
  // The falling-edge copy delays launch by half a period for default timing.
  always_ff @(negedge sdio_clk_i or negedge link_rst_n_i) begin
    if (!link_rst_n_i) begin
      fall_q <= '0;
    end else begin
      fall_q <= next_fall_q;
    end
  end
  always_comb begin
    cmd_cap_o = cmd_cap;
    dat_cap_o = dat_cap;
    // Fast timing or the rising option launches after the rising edge.
    if (launch_rise_i) begin
      {cmd_o, cmd_oe_o, dat_oe_o, dat_o} = rise_q;
    end else begin
      {cmd_o, cmd_oe_o, dat_oe_o, dat_o} = fall_q;
    end
  end
endmodule : wsp_sdio_edge

// File: bench/wsp_top_asserts.sv
// Port assertions for the enable sequencer and SDIO port.
`timescale 1ns/100ps
module wsp_top_asserts #(
  parameter int unsigned RAMP_COUNT = 8
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic wlan_enable_pin_i,
  input wire logic high_speed_timing_i,
  input wire logic launch_rising_cfg_i,
  input wire logic sdio_clk_i,
  input wire logic sdio_cmd_oe_o,
  input wire logic [3:0] sdio_dat_o,
  input wire logic sdio_dat_oe_o,
  input wire logic regulators_on_o,
  input wire logic clocks_on_o,
  input wire logic power_good_o,
  input wire logic cmd_valid_o
);
  localparam int GOOD_MAX = RAMP_COUNT + 12;
  logic [4:0] at_rise;
  logic [4:0] at_fall;
  // Each register holds the link outputs as they stood just before that edge.
  always_ff @(posedge sdio_clk_i or negedge arst_n_i)
    if (!arst_n_i) at_rise <= 5'h00;
    else at_rise <= {sdio_dat_oe_o, sdio_dat_o};
  always_ff @(negedge sdio_clk_i or negedge arst_n_i)
    if (!arst_n_i) at_fall <= 5'h00;
    else at_fall <= {sdio_dat_oe_o, sdio_dat_o};
  // Launch checks wait until the mode has stood for five link clocks, past the port's synchroniser.
  logic [4:0] mode_hist;
  logic mode_fast;
  logic mode_slow;
  always_ff @(posedge sdio_clk_i or negedge arst_n_i)
    if (!arst_n_i) mode_hist <= 5'h00;
    else mode_hist <= {mode_hist[3:0], high_speed_timing_i || launch_rising_cfg_i};
  assign mode_fast = &mode_hist;
  assign mode_slow = ~|mode_hist;
  a_off_supplies: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !wlan_enable_pin_i [*6] |-> !regulators_on_o && !clocks_on_o) else $error("supplies on while disabled");
  a_off_quiet: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !regulators_on_o |-> !cmd_valid_o && !sdio_dat_oe_o && !sdio_cmd_oe_o) else $error("activity in shutdown");
  a_good_needs_supply: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    power_good_o |-> regulators_on_o && clocks_on_o) else $error("good without supplies");
  a_ramp_start: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    wlan_enable_pin_i [*6] |-> regulators_on_o && clocks_on_o) else $error("ramp did not start");
  a_ramp_first: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    $rose(regulators_on_o) |-> !power_good_o) else $error("good before ramp");
  a_ramp_ends: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    $rose(regulators_on_o) |-> ##[1:GOOD_MAX] (power_good_o || !regulators_on_o)) else $error("ramp too long");
  a_pulse_single: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    cmd_valid_o |=> !cmd_valid_o) else $error("command pulse too long");
  a_launch_fall: assert property (@(negedge sdio_clk_i) disable iff (!arst_n_i)
    mode_slow |-> {sdio_dat_oe_o, sdio_dat_o} == at_rise)
    else $error("output moved on rising edge");
  a_launch_rise: assert property (@(posedge sdio_clk_i) disable iff (!arst_n_i)
    mode_fast |-> {sdio_dat_oe_o, sdio_dat_o} == at_fall)
    else $error("output moved on falling edge");
endmodule : wsp_top_asserts

// File: bench/wsp_host_model.sv
// Host SDIO controller model: gated link clock and command frames.
`timescale 1ns/100ps
module wsp_host_model (
  output logic sdio_clk_o,
  output logic sdio_cmd_o
);
  // The clock stands low between frames; the released line sits at its pull-up.
  initial begin
    sdio_clk_o = 1'b0;
    sdio_cmd_o = 1'b1;
  end
  task automatic run(input logic [47:0] f, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sdio_cmd_o = f[i];
      #31 sdio_clk_o = 1'b1;
      // Hold is over, so the line shows garbage at the falling edge.
      #31 sdio_cmd_o = ~f[i];
      #31.5 sdio_clk_o = 1'b0;
      #31.5;
    end
    sdio_cmd_o = 1'b1;
  endtask : run
  task automatic send(input logic [5:0] idx, input logic [31:0] arg);
    run({2'b01, idx, arg, 7'h5a, 1'b1}, 48);
  endtask : send
endmodule : wsp_host_model

// File: bench/wsp_top_tb.sv
// Self-checking testbench for the enable sequencer and SDIO port.
`timescale 1ns/100ps
module wsp_top_tb;
  import wsp_pkg::*;
  logic clock_i, arst_n_i, en, hs, cfg, irq, sclk, hcmd, cmd_o, cmd_oe, dat_oe;
  logic regs_on, clks_on, good, asleep, valid, exp_sleep;
  logic [3:0] dat_o;
  logic [5:0] idx, cmd_idx, got_idx;
  int miscompares, total_checks, got_n, cyc;
  wsp_host_model i_wsp_host_model (.sdio_clk_o(sclk), .sdio_cmd_o(hcmd));
  wsp_top #(.RAMP_COUNT(8)) i_wsp_top (.clock_i(clock_i), .arst_n_i(arst_n_i), .wlan_enable_pin_i(en),
    .high_speed_timing_i(hs), .launch_rising_cfg_i(cfg), .sdio_clk_i(sclk), .sdio_cmd_i(cmd_oe ? cmd_o : hcmd),
    .sdio_dat_i(dat_oe ? dat_o : 4'hf), .sdio_cmd_o(cmd_o), .sdio_cmd_oe_o(cmd_oe), .sdio_dat_o(dat_o),
    .sdio_dat_oe_o(dat_oe), .regulators_on_o(regs_on), .clocks_on_o(clks_on), .power_good_o(good),
    .asleep_o(asleep), .irq_req_i_dummy_o(), .irq_req_i(irq), .cmd_valid_o(valid), .cmd_index_o(cmd_idx));
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic frame(input logic [5:0] i, input logic on);
    int n;
    n = got_n;
    i_wsp_host_model.send(i, $urandom);
    for (int k = 0; k < 20 && got_n == n; k++) @(negedge clock_i);
    repeat (2) @(negedge clock_i);
    chk("frames", 8'(n + int'(on)), 8'(got_n));
    if (on) begin
      chk("index", {2'b00, i}, {2'b00, got_idx});
      if (i == CMD_SLEEP) exp_sleep = 1'b1;
      else if (i == CMD_WAKE) exp_sleep = 1'b0;
      chk("asleep", {7'h00, exp_sleep}, {7'h00, asleep});
    end
    $display("frame %h done", i);
  endtask : frame
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (valid === 1'b1) begin
      got_n++;
      got_idx = cmd_idx;
    end
    if (cyc == 40000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    {arst_n_i, en, hs, cfg, irq, exp_sleep} = 6'h00;
    void'($urandom(32'heaa1_fdab));
    repeat (6) @(negedge clock_i);
    arst_n_i = 1'b1;
    repeat (10) @(negedge clock_i);
    chk("power off", 8'h00, {5'h00, regs_on, clks_on, good});
    frame(CMD_WAKE, 1'b0);
    en = 1'b1; // Supplies and slow clock are steady before this.
    repeat (6) @(negedge clock_i);
    chk("ramp", 8'h06, {5'h00, regs_on, clks_on, good});
    for (int k = 0; k < 40 && good !== 1'b1; k++) @(negedge clock_i);
    chk("ramp done", 8'h07, {5'h00, regs_on, clks_on, good});
    // Idle clocks before the first command let the port enable cross into the link domain.
    i_wsp_host_model.run(48'hffff_ffff_ffff, 8);
    for (int k = 0; k < 12; k++) begin
      {hs, cfg} = 2'($urandom);
      case (k)
        0: idx = 6'h00;
        1: idx = 6'h3f;
        3: idx = CMD_SLEEP;
        7: idx = CMD_WAKE;
        default: idx = 6'(7 + $urandom % 57);
      endcase
      frame(idx, 1'b1);
      irq = 1'($urandom);
      i_wsp_host_model.run(48'hffff_ffff_ffff, 8);
      chk("irq", {3'b000, irq, 4'h0}, {2'b00, cmd_oe, dat_oe, dat_o});
    end
    en = 1'b0; // Supplies stay up until the enable is low.
    repeat (10) @(negedge clock_i);
    chk("shutdown", 8'h00, {4'h0, dat_oe, regs_on, clks_on, good});
    $display("shutdown done");
    summarize();
  end
endmodule : wsp_top_tb
bind wsp_top wsp_top_asserts #(.RAMP_COUNT(RAMP_COUNT)) i_wsp_top_asserts (.clock_i(clock_i), .arst_n_i(arst_n_i),
  .wlan_enable_pin_i(wlan_enable_pin_i), .high_speed_timing_i(high_speed_timing_i),
  .launch_rising_cfg_i(launch_rising_cfg_i), .sdio_clk_i(sdio_clk_i), .sdio_cmd_oe_o(sdio_cmd_oe_o),
  .sdio_dat_o(sdio_dat_o), .sdio_dat_oe_o(sdio_dat_oe_o), .regulators_on_o(regulators_on_o),
  .clocks_on_o(clocks_on_o), .power_good_o(power_good_o), .cmd_valid_o(cmd_valid_o));
